//--- core/lock_detect_output_select.sv
// Dual loop lock detect, monitor output select and serial programming with AXI4-Lite access
// Behaviour
// [RULE1] The monitor output follows select bits 17..14 of the aux reference word; 0000 gives low, 0001 high.
// [RULE2] Select 001x gives main lock, 010x aux lock, 011x both locks ANDed, bit 14 ignored.
// [RULE3] Select 100x gives the main reference divider, 101x the aux reference divider.
// [RULE4] Select 110x gives the main feedback divider, 111x the aux feedback divider.
// [RULE5] A filter locks after four consecutive reference cycles with phase error under about 15 ns.
// [RULE6] Once locked the window widens to about 30 ns and lock drops as soon as error exceeds it.
// [RULE7] A loop in powerdown holds its lock flag low.
// [RULE8] Oscillator drive is crystal mode for constant select codes, else bit 14 picks logic (0) or crystal (1).
// [RULE9] Serial data is shifted in on each rising serial clock edge.
// [RULE10] The host sends the word most significant bit first.
// [RULE11] When locked, the detector still gives minimum width up and down pump pulses.
// [RULE12] A rising load strobe moves the 18-bit shift register into the word picked by its two low bits.
// [RULE13] Each loop's polarity bit picks positive sense at one and inverts pump direction at zero.
// [RULE14] An unlocked filter restarts its count on any reference cycle with error over the narrow window.
// [RULE15] Main and aux filters run independently on their own loop's reference cycles.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module lock_detect_output_select (
    input  wire logic                               CLK,
    input  wire logic                               RST,
    input  wire logic [lock_detect_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                               S_AXI_AWVALID,
    output logic                                    S_AXI_AWREADY,
    input  wire logic [31:0]                        S_AXI_WDATA,
    input  wire logic [3:0]                         S_AXI_WSTRB,
    input  wire logic                               S_AXI_WVALID,
    output logic                                    S_AXI_WREADY,
    output logic [1:0]                              S_AXI_BRESP,
    output logic                                    S_AXI_BVALID,
    input  wire logic                               S_AXI_BREADY,
    input  wire logic [lock_detect_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                               S_AXI_ARVALID,
    output logic                                    S_AXI_ARREADY,
    output logic [31:0]                             S_AXI_RDATA,
    output logic [1:0]                              S_AXI_RRESP,
    output logic                                    S_AXI_RVALID,
    input  wire logic                               S_AXI_RREADY,
    input  wire logic                               SERIAL_CLK,
    input  wire logic                               SERIAL_DATA,
    input  wire logic                               LOAD_STROBE,
    input  wire logic                               MAIN_REFERENCE_PHASE_INPUT,
    input  wire logic                               MAIN_FEEDBACK_PHASE_INPUT,
    input  wire logic                               AUX_REFERENCE_PHASE_INPUT,
    input  wire logic                               AUX_FEEDBACK_PHASE_INPUT,
    output logic                                    MAIN_CHARGE_PUMP_OUTPUT_UP,
    output logic                                    MAIN_CHARGE_PUMP_OUTPUT_DOWN,
    output logic                                    AUX_CHARGE_PUMP_OUTPUT_UP,
    output logic                                    AUX_CHARGE_PUMP_OUTPUT_DOWN,
    output logic                                    MONITOR_OUTPUT_SELECT,
    output logic                                    OSCILLATOR_DRIVE_PIN_CRYSTAL,
    output logic                                    IRQ
);
    import lock_detect_pkg::*;

    // Pin synchronisers: stage one feeds stage two only
    logic [6:0]         sync1_reg;
    logic [6:0]         sync2_reg;
    logic               sclk_d_reg;
    logic               strobe_d_reg;
    logic               sclk_rise;
    logic               strobe_rise;
    logic               s_data;
    logic               main_ref;
    logic               main_fb;
    logic               aux_ref;
    logic               aux_fb;

    // Programming words
    logic [SHIFT_W-1:0] shift_reg;
    logic [SHIFT_W-1:0] aux_r_reg;
    logic [SHIFT_W-1:0] aux_n_reg;
    logic [SHIFT_W-1:0] main_r_reg;
    logic [SHIFT_W-1:0] main_n_reg;
    logic [3:0]         mon_sel;

    // Loop state
    logic               main_lock;
    logic               aux_lock;
    logic               main_lock_d_reg;
    logic               aux_lock_d_reg;
    logic               mon_reg;
    logic               mon_next;
    logic               xtal_reg;
    logic               xtal_next;

    // Register file and bus state
    logic [EV_W-1:0]    status_reg;
    logic [EV_W-1:0]    status_next;
    logic [EV_W-1:0]    mask_reg;
    logic [CTRL_W-1:0]  ctrl_reg;
    logic [EV_W-1:0]    events;
    logic               aw_have_reg;
    logic [ADDR_W-1:0]  aw_addr_reg;
    logic               w_have_reg;
    logic [31:0]        w_data_reg;
    logic [3:0]         w_strb_reg;
    logic               bvalid_reg;
    logic [1:0]         bresp_reg;
    logic               rvalid_reg;
    logic [31:0]        rdata_reg;
    logic [1:0]         rresp_reg;
    logic               wr_fire;
    logic [ADDR_W-1:0]  wr_word;
    logic [ADDR_W-1:0]  rd_word;
    logic [31:0]        wmask;
    logic [31:0]        wbits;
    logic [31:0]        rd_value;
    logic               rd_ok;

    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {AUX_FEEDBACK_PHASE_INPUT, AUX_REFERENCE_PHASE_INPUT, MAIN_FEEDBACK_PHASE_INPUT,
                          MAIN_REFERENCE_PHASE_INPUT, LOAD_STROBE, SERIAL_DATA, SERIAL_CLK};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sclk_d_reg   <= 1'b0;
            strobe_d_reg <= 1'b0;
        end else begin
            sclk_d_reg   <= sync2_reg[0];
            strobe_d_reg <= sync2_reg[2];
        end
    end

    assign sclk_rise   = sync2_reg[0] & ~sclk_d_reg;
    assign strobe_rise = sync2_reg[2] & ~strobe_d_reg;
    assign s_data      = sync2_reg[1];
    assign main_ref    = sync2_reg[3];
    assign main_fb     = sync2_reg[4];
    assign aux_ref     = sync2_reg[5];
    assign aux_fb      = sync2_reg[6];

    // First bit in ends up in bit 17 after eighteen shifts
    always_ff @(posedge CLK) begin
        if (RST) begin
            shift_reg <= WORD_RST;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[SHIFT_W-2:0], s_data};  // [RULE9] [RULE10]
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            aux_r_reg  <= WORD_RST;
            aux_n_reg  <= WORD_RST;
            main_r_reg <= WORD_RST;
            main_n_reg <= WORD_RST;
        end else if (strobe_rise) begin
            case (shift_reg[1:0])  // [RULE12]
                WSEL_AUX_R:  aux_r_reg  <= shift_reg;
                WSEL_AUX_N:  aux_n_reg  <= shift_reg;
                WSEL_MAIN_R: main_r_reg <= shift_reg;
                WSEL_MAIN_N: main_n_reg <= shift_reg;
                default:     aux_r_reg  <= aux_r_reg;
            endcase
        end
    end

    // Each loop filter sees only its own loop's reference and feedback edges
    loop_lock_filter u_main_filter (  // [RULE15]
        .clk       (CLK),
        .rst       (RST),
        .ref_in    (main_ref),
        .fb_in     (main_fb),
        .powerdown (ctrl_reg[CTRL_MAIN_PD]),
        .polarity  (main_r_reg[MAIN_POL_BIT]),
        .pump_up   (MAIN_CHARGE_PUMP_OUTPUT_UP),
        .pump_down (MAIN_CHARGE_PUMP_OUTPUT_DOWN),
        .lock      (main_lock)
    );

    loop_lock_filter u_aux_filter (  // [RULE15]
        .clk       (CLK),
        .rst       (RST),
        .ref_in    (aux_ref),
        .fb_in     (aux_fb),
        .powerdown (ctrl_reg[CTRL_AUX_PD]),
        .polarity  (main_r_reg[AUX_POL_BIT]),
        .pump_up   (AUX_CHARGE_PUMP_OUTPUT_UP),
        .pump_down (AUX_CHARGE_PUMP_OUTPUT_DOWN),
        .lock      (aux_lock)
    );

    assign mon_sel = aux_r_reg[MON_SEL_HI:MON_SEL_LO];

    always_comb begin
        case (mon_sel[3:1])
            MON_CONST:     mon_next = mon_sel[0];          // [RULE1]
            MON_MAIN_LOCK: mon_next = main_lock;           // [RULE2]
            MON_AUX_LOCK:  mon_next = aux_lock;            // [RULE2]
            MON_BOTH_LOCK: mon_next = main_lock & aux_lock; // [RULE2]
            MON_MAIN_REF:  mon_next = main_ref;            // [RULE3]
            MON_AUX_REF:   mon_next = aux_ref;             // [RULE3]
            MON_MAIN_FB:   mon_next = main_fb;             // [RULE4]
            MON_AUX_FB:    mon_next = aux_fb;              // [RULE4]
            default:       mon_next = 1'b0;
        endcase
        xtal_next = (mon_sel[3:1] == MON_CONST) ? 1'b1 : mon_sel[0];  // [RULE8]
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            mon_reg  <= 1'b0;
            xtal_reg <= 1'b1;
        end else begin
            mon_reg  <= mon_next;
            xtal_reg <= xtal_next;
        end
    end

    assign MONITOR_OUTPUT_SELECT        = mon_reg;
    assign OSCILLATOR_DRIVE_PIN_CRYSTAL = xtal_reg;

    // Lock edges and word loads raise sticky events
    always_ff @(posedge CLK) begin
        if (RST) begin
            main_lock_d_reg <= 1'b0;
            aux_lock_d_reg  <= 1'b0;
        end else begin
            main_lock_d_reg <= main_lock;
            aux_lock_d_reg  <= aux_lock;
        end
    end

    always_comb begin
        events               = '0;
        events[EV_MAIN_LOCK] = main_lock & ~main_lock_d_reg;
        events[EV_MAIN_LOSS] = ~main_lock & main_lock_d_reg;
        events[EV_AUX_LOCK]  = aux_lock & ~aux_lock_d_reg;
        events[EV_AUX_LOSS]  = ~aux_lock & aux_lock_d_reg;
        events[EV_WORD_LOAD] = strobe_rise;
    end

    // Write channel: address and data taken in either order, answered once both are held
    assign S_AXI_AWREADY = ~aw_have_reg & ~bvalid_reg;
    assign S_AXI_WREADY  = ~w_have_reg & ~bvalid_reg;
    assign wr_fire       = aw_have_reg & w_have_reg & ~bvalid_reg;
    assign wr_word       = {aw_addr_reg[ADDR_W-1:2], 2'b00};
    assign wmask         = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wbits         = w_data_reg & wmask;

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            w_have_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_word == OFS_STATUS || wr_word == OFS_MASK || wr_word == OFS_CONTROL) ?
                          RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP  = bresp_reg;

    always_ff @(posedge CLK) begin
        if (RST) begin
            mask_reg <= MASK_RST;
            ctrl_reg <= CTRL_RST;
        end else if (wr_fire) begin
            if (wr_word == OFS_MASK) begin
                mask_reg <= (mask_reg & ~wmask[EV_W-1:0]) | wbits[EV_W-1:0];
            end
            if (wr_word == OFS_CONTROL) begin
                ctrl_reg <= (ctrl_reg & ~wmask[CTRL_W-1:0]) | wbits[CTRL_W-1:0];
            end
        end
    end

    // Write one clears; a same-cycle event still sets
    always_comb begin
        status_next = status_reg;
        if (wr_fire && wr_word == OFS_STATUS) begin
            status_next = status_reg & ~wbits[EV_W-1:0];
        end
        status_next = status_next | events;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    assign IRQ = |(status_reg & mask_reg);

    // Read channel
    assign S_AXI_ARREADY = ~rvalid_reg;
    assign rd_word       = {S_AXI_ARADDR[ADDR_W-1:2], 2'b00};

    always_comb begin
        rd_ok    = 1'b1;
        rd_value = '0;
        case (rd_word)
            OFS_STATUS:  rd_value[EV_W-1:0]    = status_reg;
            OFS_MASK:    rd_value[EV_W-1:0]    = mask_reg;
            OFS_CONTROL: rd_value[CTRL_W-1:0]  = ctrl_reg;
            OFS_STATE:   rd_value[3:0]         = {xtal_reg, mon_reg, aux_lock, main_lock};
            OFS_AUX_R:   rd_value[SHIFT_W-1:0] = aux_r_reg;
            OFS_AUX_N:   rd_value[SHIFT_W-1:0] = aux_n_reg;
            OFS_MAIN_R:  rd_value[SHIFT_W-1:0] = main_r_reg;
            OFS_MAIN_N:  rd_value[SHIFT_W-1:0] = main_n_reg;
            default:     rd_ok                 = 1'b0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_value;
            rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA  = rdata_reg;
    assign S_AXI_RRESP  = rresp_reg;

endmodule // lock_detect_output_select

//--- pkg/lock_detect_pkg.sv
// Constants shared by the lock detect and monitor output select block
package lock_detect_pkg;

    // Timing: system clock rate and lock windows
    localparam int CLK_FREQ_MHZ      = 200;
    localparam int NARROW_WINDOW_NS  = 15;
    localparam int WIDE_WINDOW_NS    = 30;
    localparam int NARROW_WINDOW_CYC = (NARROW_WINDOW_NS * CLK_FREQ_MHZ) / 1000;
    localparam int WIDE_WINDOW_CYC   = (WIDE_WINDOW_NS * CLK_FREQ_MHZ) / 1000;
    localparam int LOCK_REF_CYCLES   = 4;
    localparam int ERR_W             = 8;
    localparam int GOOD_W            = 3;

    // Serial programming word
    localparam int SHIFT_W           = 18;
    localparam logic [1:0] WSEL_AUX_R  = 2'b00;
    localparam logic [1:0] WSEL_AUX_N  = 2'b01;
    localparam logic [1:0] WSEL_MAIN_R = 2'b10;
    localparam logic [1:0] WSEL_MAIN_N = 2'b11;
    localparam logic [SHIFT_W-1:0] WORD_RST = 18'h00000;

    // Field positions inside the programming words
    localparam int MON_SEL_HI       = 17;
    localparam int MON_SEL_LO       = 14;
    localparam int MAIN_POL_BIT     = 14;
    localparam int AUX_POL_BIT      = 15;

    // Monitor select codes, upper three bits of the field
    localparam logic [2:0] MON_CONST     = 3'h0;
    localparam logic [2:0] MON_MAIN_LOCK = 3'h1;
    localparam logic [2:0] MON_AUX_LOCK  = 3'h2;
    localparam logic [2:0] MON_BOTH_LOCK = 3'h3;
    localparam logic [2:0] MON_MAIN_REF  = 3'h4;
    localparam logic [2:0] MON_AUX_REF   = 3'h5;
    localparam logic [2:0] MON_MAIN_FB   = 3'h6;
    localparam logic [2:0] MON_AUX_FB    = 3'h7;

    // AXI4-Lite register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATE   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_AUX_R   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_AUX_N   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_MAIN_R  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MAIN_N  = 8'h1c;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Event bits of status and mask
    localparam int EV_W          = 5;
    localparam int EV_MAIN_LOCK  = 0;
    localparam int EV_MAIN_LOSS  = 1;
    localparam int EV_AUX_LOCK   = 2;
    localparam int EV_AUX_LOSS   = 3;
    localparam int EV_WORD_LOAD  = 4;
    localparam logic [EV_W-1:0] MASK_RST = 5'h00;

    // Control bits: loop powerdown
    localparam int CTRL_W        = 2;
    localparam int CTRL_MAIN_PD  = 0;
    localparam int CTRL_AUX_PD   = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

endpackage

//--- core/loop_lock_filter.sv
// Phase detector with minimum width pump pulses and digital lock filter for one loop
`timescale 1ns/10ps
module loop_lock_filter (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ref_in,
    input  wire logic fb_in,
    input  wire logic powerdown,
    input  wire logic polarity,
    output logic      pump_up,
    output logic      pump_down,
    output logic      lock
);
    import lock_detect_pkg::*;

    logic              ref_d_reg;
    logic              fb_d_reg;
    logic              up_reg;
    logic              dn_reg;
    logic [ERR_W-1:0]  err_reg;
    logic [GOOD_W-1:0] good_reg;
    logic              lock_reg;
    logic              pu_reg;
    logic              pd_reg;
    logic              ref_rise;
    logic              fb_rise;
    logic              both;

    assign ref_rise = ref_in & ~ref_d_reg;
    assign fb_rise  = fb_in & ~fb_d_reg;
    assign both     = up_reg & dn_reg;

    always_ff @(posedge clk) begin
        ref_d_reg <= rst ? 1'b0 : ref_in;
        fb_d_reg  <= rst ? 1'b0 : fb_in;
    end

    // Both sides set clears the pair next cycle, so aligned edges give one-cycle pulses
    always_ff @(posedge clk) begin
        if (rst || powerdown || both) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end else begin
            up_reg <= up_reg | ref_rise;  // [RULE11]
            dn_reg <= dn_reg | fb_rise;   // [RULE11]
        end
    end

    always_ff @(posedge clk) begin
        if (rst || powerdown) begin
            pu_reg <= 1'b0;
            pd_reg <= 1'b0;
        end else begin
            pu_reg <= polarity ? up_reg : dn_reg;  // [RULE13]
            pd_reg <= polarity ? dn_reg : up_reg;  // [RULE13]
        end
    end

    // Phase error in clock cycles between the two edges
    always_ff @(posedge clk) begin
        if (rst || powerdown || both) begin
            err_reg <= '0;
        end else if ((up_reg ^ dn_reg) && (err_reg != {ERR_W{1'b1}})) begin
            err_reg <= err_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || powerdown) begin
            good_reg <= '0;
            lock_reg <= 1'b0;  // [RULE7]
        end else if (lock_reg) begin
            if (err_reg > ERR_W'(WIDE_WINDOW_CYC)) begin
                lock_reg <= 1'b0;  // [RULE6]
                good_reg <= '0;
            end
        end else if (err_reg >= ERR_W'(NARROW_WINDOW_CYC)) begin
            good_reg <= '0;  // [RULE14]
        end else if (both) begin
            if (good_reg == GOOD_W'(LOCK_REF_CYCLES - 1)) begin
                lock_reg <= 1'b1;  // [RULE5]
            end
            good_reg <= good_reg + 1'b1;  // [RULE5]
        end
    end

    assign pump_up   = pu_reg;
    assign pump_down = pd_reg;
    assign lock      = lock_reg;

endmodule // loop_lock_filter

//--- tb/host_serial_model.sv
// Host side of the three-wire programming link
`timescale 1ns/10ps
module host_serial_model (
    output logic sclk,
    output logic sdata,
    output logic strobe
);
    initial begin
        sclk = 0;
        sdata = 0;
        strobe = 0;
    end
    // Clock idles low between frames; data flips so stale bits never look valid
    task automatic send(input logic [17:0] w);
        #7.3;
        for (int i = 17; i >= 0; i--) begin
            sdata = w[i];
            #40 sclk = 1;
            #40 sclk = 0;
        end
        sdata = ~w[0];
        #40 strobe = 1;
        #80 strobe = 0;
    endtask
endmodule // host_serial_model

//--- tb/lock_detect_monitor.sv
// Checker of bus handshakes, pump pulses and reset pin levels
`timescale 1ns/10ps
module lock_detect_monitor (
    input wire logic        CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
    input wire logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
    input wire logic        S_AXI_RREADY, MAIN_REFERENCE_PHASE_INPUT, MAIN_FEEDBACK_PHASE_INPUT,
    input wire logic        MAIN_CHARGE_PUMP_OUTPUT_UP, MAIN_CHARGE_PUMP_OUTPUT_DOWN,
    input wire logic        MONITOR_OUTPUT_SELECT, OSCILLATOR_DRIVE_PIN_CRYSTAL,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic [31:0] S_AXI_RDATA
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_aligned;
        $rose(MAIN_REFERENCE_PHASE_INPUT) && $rose(MAIN_FEEDBACK_PHASE_INPUT);
    endsequence
    a_write_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write ready during response");
    a_read_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read ready during response");
    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    a_write_answer: assert property (s_wr_taken |-> ##[2:3] S_AXI_BVALID)
        else $error("write response late");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read response late");
    a_reset_pins: assert property ($fell(RST) |-> !MONITOR_OUTPUT_SELECT && OSCILLATOR_DRIVE_PIN_CRYSTAL)
        else $error("pin levels wrong after reset");
    a_pump_pulse: assert property (s_aligned |-> ##[1:4] (MAIN_CHARGE_PUMP_OUTPUT_UP && MAIN_CHARGE_PUMP_OUTPUT_DOWN))
        else $error("no pump pulse on aligned edges");
endmodule // lock_detect_monitor
bind lock_detect_output_select lock_detect_monitor i_monitor (.*);

//--- tb/tb.sv
// Self-checking bench: register access, serial loads and lock filters
`timescale 1ns/10ps
module tb;
    import lock_detect_pkg::*;
    logic CLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID, IRQ, SERIAL_CLK, SERIAL_DATA, LOAD_STROBE;
    logic MAIN_REFERENCE_PHASE_INPUT = 0, MAIN_FEEDBACK_PHASE_INPUT = 0;
    logic AUX_REFERENCE_PHASE_INPUT = 0, AUX_FEEDBACK_PHASE_INPUT = 0, MONITOR_OUTPUT_SELECT;
    logic MAIN_CHARGE_PUMP_OUTPUT_UP, MAIN_CHARGE_PUMP_OUTPUT_DOWN, OSCILLATOR_DRIVE_PIN_CRYSTAL;
    logic AUX_CHARGE_PUMP_OUTPUT_UP, AUX_CHARGE_PUMP_OUTPUT_DOWN;
    logic [ADDR_W-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [31:0]       S_AXI_WDATA = '0, S_AXI_RDATA, rd_v, rnd;
    logic [31:0]       seed = 32'h18396dca;
    logic [3:0]        S_AXI_WSTRB = 4'hf;
    logic [1:0]        S_AXI_BRESP, S_AXI_RRESP, rsp;
    logic [17:0]       w;
    int fail_count = 0, tests_run = 0, phase = 0, main_off = 4, aux_off = 1, ml = 0, al = 0, ev = 0, old;
    int mo[6] = '{4, 0, 5, 10, 0, 0};
    int cv[6] = '{0, 0, 0, 0, 2, 0};
    lock_detect_output_select i_dut (.*);
    host_serial_model i_host (.sclk(SERIAL_CLK), .sdata(SERIAL_DATA), .strobe(LOAD_STROBE));
    always #2.5 CLK = ~CLK;
    // Reference every 40 cycles, feedback lags by the offset
    always @(posedge CLK) begin
        phase <= (phase + 1) % 40;
        MAIN_REFERENCE_PHASE_INPUT <= phase < 20;
        AUX_REFERENCE_PHASE_INPUT <= phase < 20;
        MAIN_FEEDBACK_PHASE_INPUT <= (phase + 40 - main_off) % 40 < 20;
        AUX_FEEDBACK_PHASE_INPUT <= (phase + 40 - aux_off) % 40 < 20;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bump(input int n);
        if (n >= 100) begin
            fail_count++;
            $display("CHECK FAILED %0t bus wait ran out", $time);
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, wd;
        int n;
        aw = 1;
        wd = 1;
        n = 0;
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1;
        S_AXI_WVALID <= 1;
        while ((aw || wd) && n < 100) begin
            @(negedge CLK);
            if (S_AXI_AWREADY) aw = 0;
            if (S_AXI_WREADY) wd = 0;
            @(posedge CLK);
            S_AXI_AWVALID <= aw;
            S_AXI_WVALID <= wd;
            S_AXI_BREADY <= !(aw || wd);
            n++;
        end
        while (n < 100) begin
            @(negedge CLK);
            if (S_AXI_BVALID) break;
            n++;
        end
        r = S_AXI_BRESP;
        @(posedge CLK);
        S_AXI_BREADY <= 0;
        bump(n);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t;
        int n;
        n = 0;
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1;
        S_AXI_RREADY <= 1;
        while (n < 100) begin
            @(negedge CLK);
            t = S_AXI_ARREADY;
            if (S_AXI_RVALID) break;
            @(posedge CLK);
            if (t) S_AXI_ARVALID <= 0;
            n++;
        end
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        @(posedge CLK);
        S_AXI_RREADY <= 0;
        bump(n);
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 0;
        rd(OFS_STATE, rd_v, rsp);
        check(rd_v, 32'h8);
        rd(8'h20, rd_v, rsp);
        check(rsp, RESP_SLVERR);
        wr(OFS_STATE, 32'hf, rsp);
        check(rsp, RESP_SLVERR);
        wr(OFS_MASK, 32'h1, rsp);
        // Lock filter walk; only the main lock event is unmasked
        for (int i = 0; i < 6; i++) begin
            repeat (40) if (phase < 30) @(posedge CLK);
            main_off = mo[i];
            wr(OFS_CONTROL, cv[i], rsp);
            repeat (400) @(posedge CLK);
            old = ml;
            ml = ml ? main_off <= WIDE_WINDOW_CYC : main_off < NARROW_WINDOW_CYC;
            al = cv[i][1] ? 0 : al ? aux_off <= WIDE_WINDOW_CYC : aux_off < NARROW_WINDOW_CYC;
            if (ml && !old) ev = 1;
            rd(OFS_STATE, rd_v, rsp);
            check(rd_v[1:0], {al[0], ml[0]});
            check(IRQ, ev[0]);
            wr(OFS_STATUS, 32'h1, rsp);
            ev = 0;
            check(IRQ, 1'b0);
            $display("lock step %0d done", i);
        end
        // Every select code through the serial link
        for (int c = 0; c < 16; c++) begin
            rnd = xs();
            w = {c[3:0], rnd[11:0], 2'b00};
            i_host.send(w);
            repeat (10) @(posedge CLK);
            rd(OFS_AUX_R, rd_v, rsp);
            check(rd_v, {14'h0, w});
            rd(OFS_STATE, rd_v, rsp);
            check(rd_v[3], c < 2 ? 1'b1 : c[0]);
            if (c < 8)
                check(rd_v[2], c < 2 ? c[0] : c < 4 ? ml[0] : c < 6 ? al[0] : ml[0] & al[0]);
        end
        $display("select code sweep done");
        end_of_test();
    end
endmodule // tb
